// ==== hw/cems_seq.sv ====
// Purpose: Enable, mode selection, soft start and switch gating of the regulator.
// Assumes: Analog trips arrive asynchronously and pass the pin synchroniser.
// Notes: Reference code and mode are outputs; the frame decoder sits outside.
`timescale 1ns/1ns
module cems_seq (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ctrl_pin,
    input wire logic current_trip,
    input wire logic overcurrent_trip,
    input wire logic undervoltage_lockout,
    input wire logic over_temp,
    output logic device_on,
    output logic switch_node_on,
    output logic half_limit,
    output logic single_wire_mode,
    output logic frame_accept,
    output logic ref_gate,
    output logic [cems_pkg::REF_W-1:0] softstart_step,
    output logic [cems_pkg::REF_W-1:0] wire_code_default
);
    import cems_pkg::*;

    typedef enum logic [3:0] {
        CEMS_SHUT = 4'h1,
        CEMS_DETECT = 4'h2,
        CEMS_DUTY = 4'h4,
        CEMS_WIRE = 4'h8
    } cems_state_e;

    typedef struct packed {
        cems_state_e state;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] step_cnt;
        logic [CNT_W-1:0] half_cnt;
        logic [REF_W-1:0] step;
        logic ramp_done;
        logic half;
        logic [4:0] sw_cnt;
        logic sw_on;
        logic ctrl_d;
    } cems_seq_s;

    cems_seq_s st_r, st_nxt;
    logic ctrl_s, undervoltage_lockout_s, ot_s, cur_s, oc_s;

    cems_pin_sync u_ctrl (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(ctrl_pin),
        .level_out(ctrl_s)
    );

    cems_pin_sync u_undervoltage_lockout (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(undervoltage_lockout),
        .level_out(undervoltage_lockout_s)
    );

    cems_pin_sync u_ot (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(over_temp),
        .level_out(ot_s)
    );

    cems_pin_sync u_cur (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(current_trip),
        .level_out(cur_s)
    );

    cems_pin_sync u_oc (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(overcurrent_trip),
        .level_out(oc_s)
    );

    logic running;
    logic fault;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ctrl_d = ctrl_s;
        running = (st_r.state != CEMS_SHUT);
        fault = undervoltage_lockout_s | ot_s;

        if (ctrl_s) begin
            st_nxt.low_cnt = CNT_ZERO;
        end else if (st_r.low_cnt != CNT_W'(SHUTDOWN_LOW_CYC)) begin
            st_nxt.low_cnt = st_r.low_cnt + 1'b1;
        end

        case (st_r.state)
            CEMS_SHUT: begin
                if (ctrl_s && !st_r.ctrl_d) begin
                    st_nxt.state = CEMS_DETECT;
                    st_nxt.win_cnt = CNT_ZERO;
                end
            end
            CEMS_DETECT: begin
                st_nxt.win_cnt = st_r.win_cnt + 1'b1;
                if (!ctrl_s && st_r.low_cnt == CNT_W'(DETECT_LOW_CYC)
                        && st_r.win_cnt >= CNT_W'(DETECT_DELAY_CYC + DETECT_LOW_CYC)
                        && st_r.win_cnt < CNT_W'(DETECT_WINDOW_CYC)) begin
                    st_nxt.state = CEMS_WIRE;
                end else if (st_r.win_cnt >= CNT_W'(DETECT_WINDOW_CYC)) begin
                    st_nxt.state = CEMS_DUTY;
                end
            end
            CEMS_DUTY: st_nxt.state = CEMS_DUTY;
            CEMS_WIRE: st_nxt.state = CEMS_WIRE;
            default: st_nxt.state = CEMS_SHUT;
        endcase

        if (running && st_r.low_cnt == CNT_W'(SHUTDOWN_LOW_CYC)) begin
            st_nxt.state = CEMS_SHUT;
        end
        if (st_nxt.state == CEMS_SHUT || fault) begin
            st_nxt.step = REF_RESET;
            st_nxt.step_cnt = CNT_ZERO;
            st_nxt.ramp_done = 1'b0;
            st_nxt.half_cnt = CNT_ZERO;
            st_nxt.half = 1'b1;
            st_nxt.sw_cnt = 5'h00;
            st_nxt.sw_on = 1'b0;
        end else begin
            if (!st_r.ramp_done) begin
                if (st_r.step_cnt == CNT_W'(STEP_HOLD_CYC - 1)) begin
                    st_nxt.step_cnt = CNT_ZERO;
                    if (st_r.step == REF_W'(REF_STEPS - 1)) begin
                        st_nxt.ramp_done = 1'b1;
                    end else begin
                        st_nxt.step = st_r.step + 1'b1;
                    end
                end else begin
                    st_nxt.step_cnt = st_r.step_cnt + 1'b1;
                end
            end
            if (st_r.half_cnt == CNT_W'(HALF_LIMIT_CYC - 1)) begin
                st_nxt.half = 1'b0;
            end else begin
                st_nxt.half_cnt = st_r.half_cnt + 1'b1;
            end
            if (st_r.sw_cnt == 5'(SWITCH_PERIOD_CYC - 1)) begin
                st_nxt.sw_cnt = 5'h00;
                st_nxt.sw_on = 1'b1;
            end else begin
                st_nxt.sw_cnt = st_r.sw_cnt + 1'b1;
                if (cur_s || oc_s) begin
                    st_nxt.sw_on = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '{
                state: CEMS_SHUT,
                low_cnt: CNT_ZERO,
                win_cnt: CNT_ZERO,
                step_cnt: CNT_ZERO,
                half_cnt: CNT_ZERO,
                step: REF_RESET,
                ramp_done: 1'b0,
                half: 1'b1,
                sw_cnt: 5'h00,
                sw_on: 1'b0,
                ctrl_d: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign device_on = running && !fault;
    assign switch_node_on = st_r.sw_on && device_on && !oc_s;
    assign half_limit = st_r.half;
    assign single_wire_mode = (st_r.state == CEMS_WIRE);
    assign frame_accept = (st_r.state == CEMS_WIRE) && device_on;
    assign ref_gate = device_on && ((st_r.state == CEMS_WIRE) || ctrl_s);
    assign softstart_step = st_r.step;
    assign wire_code_default = REF_FULL_SCALE;
endmodule

// ==== hw/cems_pkg.sv ====
// Purpose: Shared constants for the control-pin sequencer of the boost regulator.
// Assumes: A 20 MHz reference clock, 50 ns per cycle.
// Notes: Each count is derived from its time in its own unit.
package cems_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int CLK_NS = 50;
    // Times in microseconds; the switch frequency in kilohertz.
    localparam int SHUTDOWN_LOW_US = 2500;
    localparam int DETECT_DELAY_US = 100;
    localparam int DETECT_LOW_US = 260;
    localparam int DETECT_WINDOW_US = 1000;
    localparam int STEP_HOLD_US = 213;
    localparam int HALF_LIMIT_US = 5000;
    localparam int SWITCH_FREQ_KHZ = 1200;
    // Least times round up, longest times round down.
    localparam int SHUTDOWN_LOW_CYC = (SHUTDOWN_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int DETECT_DELAY_CYC = (DETECT_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int DETECT_LOW_CYC = (DETECT_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int DETECT_WINDOW_CYC = (DETECT_WINDOW_US * 1000) / CLK_NS;
    localparam int STEP_HOLD_CYC = (STEP_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HALF_LIMIT_CYC = (HALF_LIMIT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SWITCH_PERIOD_CYC = CLK_HZ / (SWITCH_FREQ_KHZ * 1000);
    localparam int REF_STEPS = 32;
    localparam int REF_W = 5;
    localparam logic [4:0] REF_FULL_SCALE = 5'h1F;
    localparam logic [4:0] REF_RESET = 5'h00;
    localparam int CNT_W = 18;
    localparam logic [17:0] CNT_ZERO = 18'h00000;
endpackage

// ==== hw/cems_pin_sync.sv ====
// Purpose: Three-stage synchroniser for an asynchronous level input.
// Assumes: One clock; synchronous active-high reset.
// Notes: The level changes only once the second and third stages agree.
`timescale 1ns/1ns
module cems_pin_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } cems_sync_s;
    cems_sync_s st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign level_out = st_r.lvl;
endmodule

// ==== verification/cems_seq_checker.sv ====
// Purpose: Port assertions for the control-pin sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Faults get six cycles to pass the synchroniser.
`timescale 1ns/1ns
module cems_seq_checker
    import cems_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic current_trip,
    input wire logic overcurrent_trip,
    input wire logic undervoltage_lockout,
    input wire logic over_temp,
    input wire logic device_on,
    input wire logic switch_node_on,
    input wire logic single_wire_mode,
    input wire logic frame_accept,
    input wire logic ref_gate,
    input wire logic [REF_W-1:0] softstart_step
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    int hold_r;
    logic [REF_W-1:0] prev_r;
    logic step_jump;
    // The ramp start and the clear to zero are left out, as they hold no full step.
    assign step_jump = softstart_step != prev_r && prev_r != 0 && softstart_step != 0;
    always_ff @(posedge ref_clk) begin
        prev_r <= softstart_step;
        hold_r <= (softstart_step != prev_r) ? 1 : hold_r + 1;
    end
    undervoltage_lockout_off_a: assert property (undervoltage_lockout [*6] |-> !switch_node_on)
        else $error("switch on in lockout");
    temp_off_a: assert property (over_temp [*6] |-> !device_on)
        else $error("on while hot");
    // A trip that spans a cycle start still lets that start pulse for one cycle.
    trip_off_a: assert property (current_trip [*7] |->
        !switch_node_on || $rose(switch_node_on))
        else $error("switch on after trip");
    oc_off_a: assert property (overcurrent_trip [*6] |-> !switch_node_on)
        else $error("switch on in overcurrent");
    frame_tie_a: assert property (frame_accept == (single_wire_mode && device_on))
        else $error("frame accept wrong");
    mode_lock_a: assert property ($fell(single_wire_mode) |-> !device_on)
        else $error("mode lost while on");
    ref_off_a: assert property (!device_on |-> !ref_gate)
        else $error("reference gated while off");
    step_hold_a: assert property (step_jump |-> hold_r == STEP_HOLD_CYC)
        else $error("step held wrong time");
    cover property ($rose(single_wire_mode));
    cover property (step_jump);
    cover property ($fell(device_on));
endmodule
bind cems_seq cems_seq_checker u_chk (.*);

// ==== verification/cems_host_model.sv ====
// Purpose: Host model that drives the control pin.
// Assumes: The pin changes just after a rising edge.
// Notes: The host always drives, so the pull-down never shows.
`timescale 1ns/1ns
module cems_host_model
    import cems_pkg::*;
(
    input wire logic ref_clk,
    output logic ctrl_pin
);
    initial ctrl_pin = 1'b0;
    task automatic hold(input logic lvl, input int n);
        @(posedge ref_clk) ctrl_pin <= lvl;
        repeat (n - 1) @(posedge ref_clk);
    endtask
    task automatic ask_wire();
        hold(1'b1, DETECT_DELAY_CYC + 100);
        hold(1'b0, DETECT_LOW_CYC + 100);
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Directed checks of the control-pin sequencer.
// Assumes: 50 ns clock; the run needs about 85000 cycles.
// Notes: A half-period trip keeps the switch pulsing.
`timescale 1ns/1ns
module tb_top;
    import cems_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic current_trip = 1'b0, overcurrent_trip = 1'b0;
    logic undervoltage_lockout = 1'b0, over_temp = 1'b0;
    logic ctrl_pin, device_on, switch_node_on, half_limit;
    logic single_wire_mode, frame_accept, ref_gate;
    logic [REF_W-1:0] softstart_step, wire_code_default;
    logic [3:0] ph_r = 4'h0;
    int err_total = 0;
    int n_tests = 0;
    cems_seq dut (.*);
    cems_host_model host (.ref_clk(ref_clk), .ctrl_pin(ctrl_pin));
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        ph_r <= ph_r + 4'h1;
        current_trip <= ph_r[3];
    end
    task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
        #1;
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_switch();
        int rises = 0;
        logic prev = switch_node_on;
        repeat (10 * SWITCH_PERIOD_CYC) begin
            @(posedge ref_clk);
            #1;
            if (switch_node_on && !prev) rises++;
            prev = switch_node_on;
        end
        chk("switch rises", 5'h0A, rises[4:0]);
        $display("switch done");
    endtask
    task automatic t_enable();
        host.hold(1'b1, 10);
        chk("device_on", 5'h01, device_on);
        chk("mode", 5'h00, single_wire_mode);
        chk("half_limit", 5'h01, half_limit);
        chk("ref_gate", 5'h01, ref_gate);
        chk("code", REF_FULL_SCALE, wire_code_default);
        $display("enable done");
    endtask
    task automatic t_wire();
        host.ask_wire();
        chk("mode", 5'h01, single_wire_mode);
        chk("frame_accept", 5'h01, frame_accept);
        host.hold(1'b1, 20);
        chk("step", 5'h01, softstart_step);
        $display("wire entry done");
    endtask
    task automatic t_fault();
        @(posedge ref_clk) undervoltage_lockout <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("device_on", 5'h00, device_on);
        @(posedge ref_clk) undervoltage_lockout <= 1'b0;
        over_temp <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("device_on", 5'h00, device_on);
        @(posedge ref_clk) over_temp <= 1'b0;
        overcurrent_trip <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("device_on", 5'h01, device_on);
        chk("switch", 5'h00, switch_node_on);
        @(posedge ref_clk) overcurrent_trip <= 1'b0;
        repeat (20) @(posedge ref_clk);
        t_switch();
        $display("faults done");
    endtask
    task automatic t_off();
        host.hold(1'b0, SHUTDOWN_LOW_CYC + 100);
        chk("device_on", 5'h00, device_on);
        chk("mode", 5'h00, single_wire_mode);
        chk("step", 5'h00, softstart_step);
        host.hold(1'b1, DETECT_WINDOW_CYC + 1000);
        host.hold(1'b0, DETECT_LOW_CYC + 100);
        chk("mode", 5'h00, single_wire_mode);
        chk("device_on", 5'h01, device_on);
        chk("ref_gate", 5'h00, ref_gate);
        $display("shutdown done");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        t_enable();
        t_switch();
        t_wire();
        t_fault();
        t_off();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
endmodule
